// >>> logic/phy_link_request_decoder_defines.vh
// Constants for the link request decoder
// Summary of operation
// RULE1: Frames start with a one, end with a zero, MSB first, line idles low.
// RULE2: Three bits after start give the request kind; 111 is reserved.
// RULE3: Bus request is 7 or 8 bits; speed in bits 4-6; stop optional if bit6 zero.
// RULE4: Control bus codes: 00 idle, 01 status, 10 receive, 11 grant.
// RULE5: Register read is nine bits with a four-bit address in bits 4-7.
// RULE6: Register write is seventeen bits: address bits 4-7, data bits 8-15.
// RULE7: Acceleration control is six bits; bit 4 enables or disables acceleration.
// RULE8: Invalid speed requests are arbitrated normally but transmit a null packet.
// RULE9: Link waits one clock after interface idle before fair or priority requests.
// RULE10: Receive drops pending fair/priority; overlapping receive ignores one being shifted.
// RULE11: Dropped fair/priority requests may be reissued one clock after next idle.
// RULE12: Cycle master uses priority request; isochronous only after a cycle start.
// RULE13: Pending isochronous request stays until the bus is won, despite receives.
// RULE14: Link issues immediate request during reception of a packet for it.
// RULE15: Pending immediate request is granted at once when the received packet ends.
// RULE16: On bad header CRC the link releases the grant at once, unused.
// RULE17: Link keeps only one bus request outstanding until lost or won.
// RULE18: New bus requests ignored while one is pending; bus reset clears them.
// RULE19: Register write stores data as soon as the stop bit arrives.
// RULE20: Register read returns contents by status transfer, retried until complete.
// RULE21: Register read and write requests are accepted at any time.
// RULE22: Further reads are ignored until the read contents are delivered.
// RULE23: A pending register read survives a bus reset.
// RULE24: Acceleration features work only while the enhancement enable bit is set.
// RULE25: Acceleration control acts at once; bus reset or isochronous re-enables it.
// RULE26: Link should disable acceleration at cycle rollover, re-enable on cycle start.
// RULE27: Frames with reserved kind 111 are discarded without any effect.
`ifndef PHY_LINK_REQUEST_DECODER_DEFINES_VH
`define PHY_LINK_REQUEST_DECODER_DEFINES_VH
// Interface control bus codes
`define CTL_IDLE 2'h0
`define CTL_STATUS 2'h1
`define CTL_RECEIVE 2'h2
`define CTL_GRANT 2'h3
// Request kinds
`define KIND_IMM 3'h0
`define KIND_ISO 3'h1
`define KIND_PRI 3'h2
`define KIND_FAIR 3'h3
`define KIND_RD 3'h4
`define KIND_WR 3'h5
`define KIND_ACCEL 3'h6
`define KIND_RSVD 3'h7
// Speed codes
`define SPD_S100 3'h0
`define SPD_S200 3'h2
`define SPD_S400 3'h4
// Frame lengths in bits
`define LEN_KIND 5'h04
`define LEN_ACCEL 5'h06
`define LEN_BUS_SHORT 5'h07
`define LEN_BUS_LONG 5'h08
`define LEN_RD 5'h09
`define LEN_WR 5'h11
// Register map on the software port
`define REG_STATUS_ADDR 5'h10
`define REG_ENH_INDEX 4'h5
`define ENH_EN_BIT 1
// Last count of the eight-cycle status transfer and settle time after a grant
`define STATUS_CYCLES 3'h7
`define LINK_SETTLE 2'h2
// Reset values
`define PHY_REG_RST 8'h00
`define ACCEL_RST 1'b1
`endif

// >>> logic/phy_link_request_decoder.v
// Link request decoder and interface control sequencer
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "phy_link_request_decoder_defines.vh"
module phy_link_request_decoder (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Serial request line from the link controller
  input wire link_request_line,
  // Interface control bus pin
  input wire [1:0] ctl_in,
  output reg [1:0] ctl_out_q,
  output reg ctl_oe_q,
  // Status data pins D0-D1
  output reg [1:0] status_data_q,
  output reg status_data_oe_q,
  // Serial bus core events
  input wire rx_busy,
  input wire arb_won,
  input wire bus_reset,
  input wire [3:0] status_flags,
  // Arbitration request to the serial bus core
  output reg arb_request_q,
  output reg [2:0] arb_kind_q,
  output reg [2:0] arb_speed_q,
  output reg null_packet_q,
  output reg accel_active_q,
  // Software register port
  input wire [4:0] sw_addr,
  input wire [7:0] sw_wdata,
  input wire sw_wr,
  input wire sw_rd,
  output reg [7:0] sw_rdata_q
);

  localparam ST_IDLE = 3'h0;
  localparam ST_STATUS = 3'h1;
  localparam ST_RECEIVE = 3'h2;
  localparam ST_GRANT = 3'h3;
  localparam ST_LINK = 3'h4;

  function is_fair_pri;
    input [2:0] k;
    begin
      is_fair_pri = (k == `KIND_PRI) || (k == `KIND_FAIR);
    end
  endfunction

  function speed_ok;
    input [2:0] s;
    begin
      speed_ok = (s == `SPD_S100) || (s == `SPD_S200) || (s == `SPD_S400);
    end
  endfunction

  // Pin synchronisers
  reg link_request_line_m_q;
  reg link_request_line_s_q;
  reg [1:0] ctl_m_q;
  reg [1:0] ctl_s_q;

  // Frame shifter
  reg [4:0] cnt_q;
  reg [15:0] sh_q;
  reg [2:0] kind_q;
  reg ovl_q;

  // Pending state
  reg bus_pend_q;
  reg rd_pend_q;
  reg [3:0] rd_addr_q;
  reg accel_on_q;

  // Interface sequencer
  reg [2:0] st_q;
  reg [2:0] scnt_q;
  reg [1:0] settle_q;
  reg idle_gap_q;
  reg [15:0] stat_word_q;
  reg [7:0] phy_reg [0:15];
  wire [16:0] new_sh = {sh_q, link_request_line_s_q};
  wire [4:0] n_bits = cnt_q + 5'h01;
  wire in_frame = (cnt_q != 5'h00);
  wire rx_now = (st_q == ST_RECEIVE);
  // Frame completion decode
  reg bus_done;
  reg [2:0] bus_speed;
  reg rd_done;
  reg wr_done;
  reg acc_done;
  reg frame_end;
  always @* begin
    bus_done = 1'b0;
    bus_speed = 3'h0;
    rd_done = 1'b0;
    wr_done = 1'b0;
    acc_done = 1'b0;
    frame_end = 1'b0;
    if (in_frame) begin
      if (n_bits == `LEN_KIND && new_sh[2:0] == `KIND_RSVD) begin
        frame_end = 1'b1; // [RULE27]
      end else if (!kind_q[2]) begin
        // Stop bit may be absent when the last speed bit is zero
        if (n_bits == `LEN_BUS_SHORT && !new_sh[0]) begin
          bus_done = 1'b1; // [RULE3]
          bus_speed = new_sh[2:0];
        end else if (n_bits == `LEN_BUS_LONG) begin
          bus_done = 1'b1; // [RULE3]
          bus_speed = new_sh[3:1];
        end
      end else if (kind_q == `KIND_RD && n_bits == `LEN_RD) begin
        rd_done = 1'b1; // [RULE5]
      end else if (kind_q == `KIND_WR && n_bits == `LEN_WR) begin
        wr_done = 1'b1; // [RULE6]
      end else if (kind_q == `KIND_ACCEL && n_bits == `LEN_ACCEL) begin
        acc_done = 1'b1; // [RULE7]
      end
      if (bus_done || rd_done || wr_done || acc_done) begin
        frame_end = 1'b1;
      end
    end
  end

  // Drop of a pending fair or priority request by a receive
  wire drop_fp = bus_pend_q && is_fair_pri(arb_kind_q) && rx_now; // [RULE10]
  wire bus_accept = bus_done && !bus_pend_q && !bus_reset &&
                    !(is_fair_pri(kind_q) && (ovl_q || rx_now)); // [RULE18] [RULE10]
  wire imm_grant = bus_pend_q && (arb_kind_q == `KIND_IMM) && rx_now && !rx_busy; // [RULE15]
  wire arb_grant = bus_pend_q && (arb_kind_q != `KIND_IMM) && arb_won &&
                   (st_q == ST_IDLE || st_q == ST_STATUS);
  wire status_done = (st_q == ST_STATUS) && (scnt_q == `STATUS_CYCLES) && !rx_busy;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      link_request_line_m_q <= 1'b0;
      link_request_line_s_q <= 1'b0;
      ctl_m_q <= 2'h0;
      ctl_s_q <= 2'h0;
    end else begin
      link_request_line_m_q <= link_request_line;
      link_request_line_s_q <= link_request_line_m_q;
      ctl_m_q <= ctl_in;
      ctl_s_q <= ctl_m_q;
    end
  end

  // Request shifter, MSB first, start bit one
  always @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      kind_q <= 3'h0;
      ovl_q <= 1'b0;
    end else if (!in_frame) begin
      sh_q <= {15'h0000, link_request_line_s_q};
      ovl_q <= rx_now;
      if (link_request_line_s_q) begin
        cnt_q <= 5'h01; // [RULE1]
      end
    end else begin
      sh_q <= new_sh[15:0];
      if (rx_now) begin
        ovl_q <= 1'b1;
      end
      if (n_bits == `LEN_KIND) begin
        kind_q <= new_sh[2:0]; // [RULE2]
      end
      if (frame_end) begin
        cnt_q <= 5'h00;
      end else begin
        cnt_q <= n_bits;
      end
    end
  end

  // Bus request pending state and arbitration request
  always @(posedge core_clk) begin
    if (!rst_b) begin
      bus_pend_q <= 1'b0;
      arb_request_q <= 1'b0;
      arb_kind_q <= 3'h0;
      arb_speed_q <= 3'h0;
      null_packet_q <= 1'b0;
    end else begin
      if (bus_reset) begin
        bus_pend_q <= 1'b0; // [RULE18]
        arb_request_q <= 1'b0;
      end else if (imm_grant || arb_grant || drop_fp) begin
        // Isochronous stays pending through receives, cleared only on a win or a bus reset
        bus_pend_q <= 1'b0; // [RULE13]
        arb_request_q <= 1'b0;
      end else if (bus_accept) begin
        bus_pend_q <= 1'b1;
        arb_request_q <= (kind_q != `KIND_IMM);
        arb_kind_q <= kind_q;
        arb_speed_q <= bus_speed;
      end
      if (imm_grant || arb_grant) begin
        null_packet_q <= !speed_ok(arb_speed_q); // [RULE8]
      end else if (st_q == ST_LINK && settle_q == 2'h0 && ctl_s_q == `CTL_IDLE) begin
        null_packet_q <= 1'b0;
      end
    end
  end

  // Register file, read pending, acceleration
  always @(posedge core_clk) begin
    if (!rst_b) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 4'h0;
      accel_on_q <= `ACCEL_RST;
      accel_active_q <= 1'b0;
      sw_rdata_q <= 8'h00;
    end else begin
      if (wr_done) begin
        phy_reg[new_sh[12:9]] <= new_sh[8:1]; // [RULE19] [RULE21]
      end else if (sw_wr && !sw_addr[4]) begin
        phy_reg[sw_addr[3:0]] <= sw_wdata;
      end
      // Bus reset leaves the read pending
      if (rd_done && !rd_pend_q) begin
        rd_pend_q <= 1'b1; // [RULE21] [RULE22] [RULE23]
        rd_addr_q <= new_sh[4:1];
      end else if (status_done) begin
        rd_pend_q <= 1'b0; // [RULE20]
      end
      if (acc_done) begin
        accel_on_q <= new_sh[1]; // [RULE25]
      end else if (bus_reset || (bus_accept && kind_q == `KIND_ISO)) begin
        accel_on_q <= 1'b1; // [RULE25]
      end
      accel_active_q <= accel_on_q && phy_reg[`REG_ENH_INDEX][`ENH_EN_BIT]; // [RULE24]
      if (sw_rd) begin
        if (!sw_addr[4]) begin
          sw_rdata_q <= phy_reg[sw_addr[3:0]];
        end else if (sw_addr == `REG_STATUS_ADDR) begin
          sw_rdata_q <= {bus_pend_q, arb_kind_q, rd_pend_q, accel_on_q, st_q[1:0]};
        end else begin
          sw_rdata_q <= 8'h00;
        end
      end else begin
        sw_rdata_q <= 8'h00;
      end
    end
  end

  // Interface control sequencer
  always @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      scnt_q <= 3'h0;
      settle_q <= 2'h0;
      idle_gap_q <= 1'b0;
      stat_word_q <= 16'h0000;
      ctl_out_q <= `CTL_IDLE;
      ctl_oe_q <= 1'b1;
      status_data_q <= 2'h0;
      status_data_oe_q <= 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: begin
          idle_gap_q <= 1'b1;
          ctl_oe_q <= 1'b1;
          status_data_oe_q <= 1'b1;
          status_data_q <= 2'h0;
          if (rx_busy) begin
            st_q <= ST_RECEIVE;
            ctl_out_q <= `CTL_RECEIVE; // [RULE4]
          end else if (arb_grant) begin
            st_q <= ST_GRANT;
            ctl_out_q <= `CTL_GRANT;
          end else if (rd_pend_q && idle_gap_q) begin
            st_q <= ST_STATUS;
            scnt_q <= 3'h0;
            ctl_out_q <= `CTL_STATUS;
            stat_word_q <= {status_flags, rd_addr_q, phy_reg[rd_addr_q]};
            status_data_q <= status_flags[3:2];
          end else begin
            ctl_out_q <= `CTL_IDLE;
          end
        end
        ST_STATUS: begin
          idle_gap_q <= 1'b0;
          if (rx_busy) begin
            // Interrupted transfer is retried while the read stays pending
            st_q <= ST_RECEIVE; // [RULE20]
            ctl_out_q <= `CTL_RECEIVE;
            status_data_q <= 2'h0;
          end else if (arb_grant) begin
            st_q <= ST_GRANT;
            ctl_out_q <= `CTL_GRANT;
            status_data_q <= 2'h0;
          end else if (status_done) begin
            st_q <= ST_IDLE;
            ctl_out_q <= `CTL_IDLE;
            status_data_q <= 2'h0;
          end else begin
            scnt_q <= scnt_q + 3'h1;
            status_data_q <= stat_word_q[4'hc - {scnt_q, 1'b0} +: 2];
          end
        end
        ST_RECEIVE: begin
          idle_gap_q <= 1'b0;
          status_data_q <= 2'h0;
          if (imm_grant) begin
            st_q <= ST_GRANT; // [RULE15]
            ctl_out_q <= `CTL_GRANT;
          end else if (!rx_busy) begin
            st_q <= ST_IDLE;
            ctl_out_q <= `CTL_IDLE;
          end
        end
        ST_GRANT: begin
          // Grant shown for one cycle, then the pins go to the link
          st_q <= ST_LINK;
          settle_q <= `LINK_SETTLE;
          ctl_oe_q <= 1'b0;
          status_data_oe_q <= 1'b0;
          ctl_out_q <= `CTL_IDLE;
        end
        ST_LINK: begin
          if (settle_q != 2'h0) begin
            settle_q <= settle_q - 2'h1;
          end else if (ctl_s_q == `CTL_IDLE) begin
            // Link release, including an immediate cancel of the grant
            st_q <= ST_IDLE; // [RULE16]
            ctl_oe_q <= 1'b1;
            status_data_oe_q <= 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          ctl_out_q <= `CTL_IDLE;
          ctl_oe_q <= 1'b1;
        end
      endcase
    end
  end
endmodule

// >>> verif/link_ctrl_model.sv
// Behavioural link controller driving the serial request line
`timescale 1ns/1ps
module link_ctrl_model (
  // Clock
  input wire core_clk,
  // Request line and control bus drive
  output logic link_request_line,
  output logic [1:0] link_ctl
);
  initial begin
    link_request_line = 1'b0;
    link_ctl = 2'h0;
  end
  // Frame is right-aligned; one idle clock goes before it
  task automatic send(input logic [16:0] bits, input int n);
    @(posedge core_clk);
    for (int i = n - 1; i >= 0; i--) begin
      link_request_line <= bits[i];
      @(posedge core_clk);
    end
    link_request_line <= 1'b0;
  endtask
endmodule

// >>> verif/phy_link_request_decoder_chk.sv
// Checker for the link request decoder ports
`timescale 1ns/1ps
module phy_link_request_decoder_chk (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Watched ports
  input wire [1:0] ctl_out_q,
  input wire ctl_oe_q,
  input wire rx_busy,
  input wire arb_won,
  input wire bus_reset,
  input wire arb_request_q,
  input wire [2:0] arb_kind_q,
  input wire accel_active_q,
  input wire [4:0] sw_addr,
  input wire [7:0] sw_wdata,
  input wire sw_wr,
  input wire sw_rd,
  input wire [7:0] sw_rdata_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  rdata_idle_a: assert property (!$past(sw_rd) |-> sw_rdata_q == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (sw_rd && sw_addr > 5'h10 |=> sw_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  write_read_a: assert property (sw_wr && sw_addr < 5'h10 ##1 sw_rd && sw_addr == $past(sw_addr)
    |=> sw_rdata_q == $past(sw_wdata, 2))
    else $error("read back differs from write");
  grant_once_a: assert property (ctl_oe_q && ctl_out_q == 2'h3 |=> !ctl_oe_q)
    else $error("grant not released after one cycle");
  reset_clear_a: assert property (bus_reset |=> !arb_request_q)
    else $error("bus request survived bus reset");
  iso_hold_a: assert property (arb_request_q && arb_kind_q == 3'h1 && rx_busy && !arb_won
    && !bus_reset |=> arb_request_q)
    else $error("isochronous request lost on receive");
  fair_drop_a: assert property (ctl_oe_q && ctl_out_q == 2'h2 && arb_request_q
    && arb_kind_q[2:1] == 2'b01 |=> !arb_request_q)
    else $error("fair or priority request kept in receive");
  receive_show_a: assert property ($rose(rx_busy) && ctl_oe_q && ctl_out_q != 2'h3
    |-> ##[1:2] ctl_out_q == 2'h2)
    else $error("receive not shown on control bus");
  accel_off_a: assert property (sw_wr && sw_addr == 5'h05 && !sw_wdata[1]
    |-> ##[1:2] !accel_active_q)
    else $error("acceleration active without enable bit");
endmodule
bind phy_link_request_decoder phy_link_request_decoder_chk chk (
  .core_clk(core_clk), .rst_b(rst_b), .ctl_out_q(ctl_out_q), .ctl_oe_q(ctl_oe_q),
  .rx_busy(rx_busy), .arb_won(arb_won), .bus_reset(bus_reset), .arb_request_q(arb_request_q),
  .arb_kind_q(arb_kind_q), .accel_active_q(accel_active_q), .sw_addr(sw_addr),
  .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q)
);

// >>> verif/phy_link_request_decoder_test.sv
// Self-checking bench for the link request decoder
`timescale 1ns/1ps
module phy_link_request_decoder_test;
  logic core_clk, rst_b, rx_busy, arb_won, bus_reset, sw_wr, sw_rd, link_request_line;
  logic ctl_oe_q, status_data_oe_q, arb_request_q, null_packet_q, accel_active_q;
  logic [1:0] ctl_out_q, status_data_q, link_ctl;
  logic [2:0] arb_kind_q, arb_speed_q;
  logic [3:0] flags = 4'h9;
  logic [4:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata_q;
  logic [15:0] st;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // Control bus wire level from both drivers
  wire [1:0] ctl_in = ctl_oe_q ? ctl_out_q : link_ctl;
  phy_link_request_decoder dut (.core_clk(core_clk), .rst_b(rst_b),
    .link_request_line(link_request_line), .ctl_in(ctl_in), .ctl_out_q(ctl_out_q),
    .ctl_oe_q(ctl_oe_q), .status_data_q(status_data_q), .status_data_oe_q(status_data_oe_q),
    .rx_busy(rx_busy), .arb_won(arb_won), .bus_reset(bus_reset), .status_flags(flags),
    .arb_request_q(arb_request_q), .arb_kind_q(arb_kind_q), .arb_speed_q(arb_speed_q),
    .null_packet_q(null_packet_q), .accel_active_q(accel_active_q), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q));
  link_ctrl_model link (.core_clk(core_clk), .link_request_line(link_request_line),
    .link_ctl(link_ctl));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Raises rx_busy, or bus_reset when to_reset is set, for n cycles
  task automatic pulse(input bit to_reset, input int n);
    @(posedge core_clk);
    if (to_reset) begin
      bus_reset <= 1'b1;
    end else begin
      rx_busy <= 1'b1;
    end
    repeat (n) @(posedge core_clk);
    bus_reset <= 1'b0;
    rx_busy <= 1'b0;
    tick(2);
  endtask
  task automatic sw_write_read(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1;
    check("sw_rdata_q", {8'h00, d}, {8'h00, sw_rdata_q});
  endtask
  task automatic sw_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [4:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1;
    check("sw_rdata_q", {8'h00, exp}, {8'h00, sw_rdata_q});
  endtask
  task automatic frame(input logic [16:0] f, input int n);
    link.send(f, n);
    tick(4);
  endtask
  task automatic bus_req(input logic [2:0] k, input logic [2:0] s);
    if (s[0]) frame({9'h000, 1'b1, k, s, 1'b0}, 8);
    else frame({10'h000, 1'b1, k, s}, 7);
  endtask
  task automatic get_status();
    for (int i = 0; i < 300 && !(ctl_oe_q === 1'b1 && ctl_out_q === 2'h1); i++) tick(1);
    for (int i = 0; i < 8; i++) begin
      st = {st[13:0], status_data_q};
      tick(1);
    end
  endtask
  task automatic wait_grant();
    #1;
    for (int i = 0; i < 100 && !(ctl_oe_q === 1'b1 && ctl_out_q === 2'h3); i++) tick(1);
    check("grant", 16'h0003, {14'h0000, ctl_out_q});
  endtask
  function automatic logic [15:0] pend();
    return {9'h000, arb_request_q, arb_kind_q, arb_speed_q};
  endfunction
  initial begin
    rst_b = 1'b0;
    rx_busy = 1'b0;
    arb_won = 1'b0;
    bus_reset = 1'b0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    sw_addr = 5'h00;
    sw_wdata = 8'h00;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(3);
    check("ctl", 16'h0001, {13'h0000, ctl_out_q, ctl_oe_q});
    sw_write_read(5'h03, 8'ha5);
    sw_read(5'h11, 8'h00);
    frame({1'b1, 3'h5, 4'h4, 8'h3c, 1'b0}, 17);
    sw_read(5'h04, 8'h3c);
    frame({13'h0000, 1'b1, 3'h7}, 4);
    sw_read(5'h04, 8'h3c);
    check("arb_request_q", 16'h0000, pend() & 16'h0040);
    bus_req(3'h3, 3'h2);
    check("bus_request", 16'h005a, pend());
    bus_req(3'h2, 3'h4);
    check("bus_request", 16'h005a, pend());
    sw_read(5'h10, 8'hb4);
    link.send({8'h00, 1'b1, 3'h4, 4'h4, 1'b0}, 9);
    for (int i = 0; i < 50 && ctl_out_q !== 2'h1; i++) tick(1);
    pulse(1'b0, 3);
    check("arb_request_q", 16'h0000, pend() & 16'h0040);
    get_status();
    check("status", {4'h9, 4'h4, 8'h3c}, st);
    bus_req(3'h1, 3'h0);
    pulse(1'b0, 3);
    check("bus_request", 16'h0048, pend());
    pulse(1'b1, 1);
    check("arb_request_q", 16'h0000, pend() & 16'h0040);
    sw_write(5'h05, 8'h02);
    frame({11'h000, 1'b1, 3'h6, 1'b0, 1'b0}, 6);
    check("accel_active_q", 16'h0000, {15'h0000, accel_active_q});
    frame({11'h000, 1'b1, 3'h6, 1'b1, 1'b0}, 6);
    check("accel_active_q", 16'h0001, {15'h0000, accel_active_q});
    frame({11'h000, 1'b1, 3'h6, 1'b0, 1'b0}, 6);
    pulse(1'b1, 1);
    check("accel_active_q", 16'h0001, {15'h0000, accel_active_q});
    sw_write(5'h05, 8'h00);
    tick(2);
    check("accel_active_q", 16'h0000, {15'h0000, accel_active_q});
    bus_req(3'h2, 3'h7);
    check("bus_request", 16'h0057, pend());
    @(posedge core_clk);
    arb_won <= 1'b1;
    @(posedge core_clk);
    arb_won <= 1'b0;
    wait_grant();
    check("null_packet_q", 16'h0001, {15'h0000, null_packet_q});
    tick(1);
    check("status_data_oe_q", 16'h0000, {15'h0000, status_data_oe_q});
    tick(10);
    check("ctl", 16'h0001, {13'h0000, ctl_out_q, ctl_oe_q});
    @(posedge core_clk);
    rx_busy <= 1'b1;
    bus_req(3'h0, 3'h0);
    @(posedge core_clk);
    rx_busy <= 1'b0;
    wait_grant();
    tick(10);
    finish_test();
  end
endmodule
